// ==== common/cmd_cfg_pkg.sv ====
package cmd_cfg_pkg;

  // Register addresses used with the generic read/write commands (arbitrary placement)
  localparam logic [23:0] NV_REG_ADDR       = 24'h000004;
  localparam logic [23:0] V_REG_ADDR        = 24'h800004;

  // Command opcodes
  localparam logic [7:0]  CMD_REG_READ      = 8'h65;
  localparam logic [7:0]  CMD_REG_WRITE     = 8'h71;
  localparam logic [7:0]  CMD_LEGACY_RESET  = 8'hF0;
  localparam logic [7:0]  CMD_RESET_ENABLE  = 8'h66;
  localparam logic [7:0]  CMD_RESET         = 8'h99;

  // Field positions
  localparam int          BIT_BLANK_CHECK   = 5;
  localparam int          BIT_BUF_WRAP      = 4;
  localparam int          BIT_SMALL_SECT    = 3;
  localparam int          BIT_LEGACY_RESET  = 0;
  localparam logic [7:0]  DEFINED_MASK      = 8'h39;

  // Delivered (factory) value of the non-volatile copy
  localparam logic [7:0]  NV_RESET_VALUE    = 8'h00;

  // Page buffer sizes
  localparam logic [8:0]  PAGE_MASK_SMALL   = 9'h0FF;
  localparam logic [8:0]  PAGE_MASK_LARGE   = 9'h1FF;

  // Small-sector overlay span: 32 KB as a byte address width
  localparam int          OVERLAY_BITS      = 15;

  // Erase command kinds
  typedef enum logic [1:0] {
    ERASE_PARAM,
    ERASE_SECTOR,
    ERASE_BULK
  } erase_kind_type;

  // Command channel from the serial front end
  typedef struct packed {
    logic        valid;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [7:0]  wdata;
  } cmd_req_type;

  // Register read reply
  typedef struct packed {
    logic        valid;
    logic [7:0]  rdata;
    logic        err;
  } cmd_rsp_type;

  // Erase request and the engine answers that blank check needs
  typedef struct packed {
    logic           start;
    erase_kind_type kind;
    logic           last_erase_ok;
  } erase_req_type;

  typedef struct packed {
    logic blank_done;
    logic blank_found_zero;
  } blank_rsp_type;

  // Erase engine commands
  typedef struct packed {
    logic blank_read_start;
    logic erase_start;
    logic skipped;
  } erase_ctl_type;

endpackage : cmd_cfg_pkg

// ==== src/command_behavior_config_reg.sv ====
`timescale 1ns/10ps

module command_behavior_config_reg (
  // Clock and resets
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_in,
  input  wire logic                       hw_reset_in,
  // Decoded commands from the serial front end
  input  wire cmd_cfg_pkg::cmd_req_type   cmd_in,
  // Erase engine request and blank-read answers
  input  wire cmd_cfg_pkg::erase_req_type erase_in,
  input  wire cmd_cfg_pkg::blank_rsp_type blank_in,
  // Addresses to wrap and classify
  input  wire logic [8:0]                 buf_addr_in,
  input  wire logic                       top_param_in,
  input  wire logic [31:0]                array_addr_in,
  // Register read answers
  output cmd_cfg_pkg::cmd_rsp_type        rsp_out,
  // Erase engine control
  output cmd_cfg_pkg::erase_ctl_type      erase_ctl_out,
  output logic                            erase_busy_out,
  // Wrapped and classified addresses
  output logic [8:0]                      buf_addr_out,
  output logic                            small_sector_hit_out,
  // Reset pulse and the working copy
  output logic                            soft_reset_out,
  output logic [7:0]                      cfg_volatile_out
);

  // Erase sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BLANK_READ,
    ST_ERASE
  } erase_state_type;

  typedef struct packed {
    // Boot copy and working copy of the register
    logic [7:0]                 nv;
    logic [7:0]                 vol;
    // Set by 66h, used by a directly following 99h
    logic                       reset_armed;
    erase_state_type            est;
    // Registered outputs
    cmd_cfg_pkg::cmd_rsp_type   rsp;
    cmd_cfg_pkg::erase_ctl_type ectl;
    logic                       busy;
    logic [8:0]                 baddr;
    logic                       ss_hit;
    logic                       sreset;
  } state_type;

  state_type state_r;
  state_type state_nxt;

  // Next-state logic for the whole block
  always_comb begin
    // Command decode
    logic        op_read;
    logic        op_write;
    logic        op_legacy;
    logic        op_arm;
    logic        op_fire;
    logic        sel_nv;
    logic        sel_vol;

    // Reset decode
    logic        legacy_rst;
    logic        seq_rst;
    logic        any_rst;

    // Erase qualifiers
    logic        check_on;
    logic        last_ok;

    // Write data
    logic [7:0]  wmask;
    logic [7:0]  vol_wr;

    // Datapath
    logic [8:0]  wrap_mask;
    logic [16:0] hi_bits;
    logic        in_top;
    logic        in_bottom;
    logic        hybrid;
    // Every local starts from a known value so no path leaves a latch
    op_read    = 1'b0;
    op_write   = 1'b0;
    op_legacy  = 1'b0;
    op_arm     = 1'b0;
    op_fire    = 1'b0;
    sel_nv     = 1'b0;
    sel_vol    = 1'b0;
    legacy_rst = 1'b0;
    seq_rst    = 1'b0;
    any_rst    = 1'b0;
    check_on   = 1'b0;
    last_ok    = 1'b0;
    wmask      = 8'h00;
    vol_wr     = 8'h00;
    wrap_mask  = 9'h000;
    hi_bits    = 17'h00000;
    in_top     = 1'b0;
    in_bottom  = 1'b0;
    hybrid     = 1'b0;
    state_nxt  = state_r;
    // Pulse outputs fall back to zero unless set below
    state_nxt.rsp    = '0;
    state_nxt.ectl   = '0;
    state_nxt.sreset = 1'b0;

    // Opcode decode; only a valid command counts
    // Reads and writes share one address decode below
    if (cmd_in.valid) begin
      unique case (cmd_in.opcode)
        cmd_cfg_pkg::CMD_REG_READ:     op_read   = 1'b1;
        cmd_cfg_pkg::CMD_REG_WRITE:    op_write  = 1'b1;
        cmd_cfg_pkg::CMD_LEGACY_RESET: op_legacy = 1'b1;
        cmd_cfg_pkg::CMD_RESET_ENABLE: op_arm    = 1'b1;
        cmd_cfg_pkg::CMD_RESET:        op_fire   = 1'b1;
        // Other commands belong to other blocks and are let pass
        default:                       op_read   = 1'b0;
      endcase
    end

    // Address decode of the two copies; any other address is refused
    sel_nv  = (cmd_in.addr == cmd_cfg_pkg::NV_REG_ADDR);
    sel_vol = (cmd_in.addr == cmd_cfg_pkg::V_REG_ADDR);

    // Single-byte reset honoured only while the working copy enables it
    legacy_rst = op_legacy && state_r.vol[cmd_cfg_pkg::BIT_LEGACY_RESET];
    // Pair form ignores the enable bit
    seq_rst = op_fire && state_r.reset_armed;
    // Any command other than the enable disarms, so 99h must follow 66h directly
    if (cmd_in.valid) begin
      state_nxt.reset_armed = op_arm;
    end
    // A hardware reset request counts as well; each high cycle reloads
    any_rst = legacy_rst | seq_rst | hw_reset_in;

    // Reserved positions are dropped before any copy is touched
    wmask = cmd_in.wdata & cmd_cfg_pkg::DEFINED_MASK;
    vol_wr = wmask;
    // Layout bit follows only the OTP bit; a stray write cannot split the copies
    // A host that keeps the rule sees no difference
    vol_wr[cmd_cfg_pkg::BIT_SMALL_SECT] = state_r.vol[cmd_cfg_pkg::BIT_SMALL_SECT];

    // Register reads; a reset in the same cycle wins and the read is dropped
    // The answer is registered, so it stands one cycle after the command
    if (op_read && !any_rst) begin
      state_nxt.rsp.valid = 1'b1;
      if (sel_nv) begin
        state_nxt.rsp.rdata = state_r.nv & cmd_cfg_pkg::DEFINED_MASK;
      end else if (sel_vol) begin
        state_nxt.rsp.rdata = state_r.vol & cmd_cfg_pkg::DEFINED_MASK;
      end else begin
        // Unmapped address: flagged, data left at zero
        state_nxt.rsp.err = 1'b1;
      end
    end

    // Register writes; good writes are silent, unmapped ones report an error
    // A good write lands at the next edge
    if (op_write && !any_rst) begin
      if (sel_nv) begin
        // OTP: a bit can only be set away from its delivered zero, never cleared
        state_nxt.nv = state_r.nv | wmask;
      end else if (sel_vol) begin
        state_nxt.vol = vol_wr;
      end else begin
        state_nxt.rsp.valid = 1'b1;
        state_nxt.rsp.err   = 1'b1;
      end
    end

    // Blank-check qualifiers, taken with the erase request
    // A failed history skips the blank read entirely
    check_on = state_r.vol[cmd_cfg_pkg::BIT_BLANK_CHECK];
    last_ok  = erase_in.last_erase_ok;

    // Reload working copy; any erase in flight is abandoned
    // Reserved bits of the boot copy never reach the working copy
    if (any_rst) begin
      state_nxt.vol = state_r.nv & cmd_cfg_pkg::DEFINED_MASK;
      state_nxt.sreset = legacy_rst | seq_rst;
      state_nxt.reset_armed = 1'b0;
      state_nxt.est = ST_IDLE;
      state_nxt.busy = 1'b0;
    end else begin
      // Erase sequencing; the three erase kinds share one path
      unique case (state_r.est)
        ST_IDLE: begin
          if (erase_in.start) begin
            state_nxt.busy = 1'b1;
            if (check_on && last_ok) begin
              // Good history: read first, erase only if something is programmed
              state_nxt.ectl.blank_read_start = 1'b1;
              state_nxt.est = ST_BLANK_READ;
            end else begin
              // Disabled check, or a failed previous erase: erase right away
              state_nxt.ectl.erase_start = 1'b1;
              state_nxt.est = ST_ERASE;
            end
          end
        end
        ST_BLANK_READ: begin
          // A found zero beats a done in the same cycle
          if (blank_in.blank_found_zero) begin
            state_nxt.ectl.erase_start = 1'b1;
            state_nxt.est = ST_ERASE;
          end else if (blank_in.blank_done) begin
            state_nxt.ectl.skipped = 1'b1;
            state_nxt.busy = 1'b0;
            state_nxt.est = ST_IDLE;
          end
        end
        ST_ERASE: begin
          // The engine's completion is reported as blank_done as well
          // Erase timing belongs to the engine; this block only waits
          if (blank_in.blank_done) begin
            state_nxt.busy = 1'b0;
            state_nxt.est = ST_IDLE;
          end
        end
        default: begin
          // Unused state code: drop back to idle rather than lock up
          state_nxt.busy = 1'b0;
          state_nxt.est = ST_IDLE;
        end
      endcase
    end

    // Wrap point: 256 bytes unless the working copy selects the full buffer
    // Masking instead of a carry keeps the wrap free of an adder
    if (state_r.vol[cmd_cfg_pkg::BIT_BUF_WRAP]) begin
      wrap_mask = cmd_cfg_pkg::PAGE_MASK_LARGE;
    end else begin
      wrap_mask = cmd_cfg_pkg::PAGE_MASK_SMALL;
    end
    // Registered, so the wrapped address trails the raw one by a cycle
    state_nxt.baddr = buf_addr_in & wrap_mask;

    // Overlay region: bits above 32 KB all ones at the top, all zero at the bottom
    // Top or bottom placement comes from the parameter location select
    hi_bits   = array_addr_in[31:cmd_cfg_pkg::OVERLAY_BITS];
    in_top    = &hi_bits;
    in_bottom = (hi_bits == 17'h00000);
    hybrid    = !state_r.vol[cmd_cfg_pkg::BIT_SMALL_SECT];
    // Uniform layout removes the 4 KB sectors, so nothing is a hit
    if (!hybrid) begin
      state_nxt.ss_hit = 1'b0;
    end else if (top_param_in) begin
      state_nxt.ss_hit = in_top;
    end else begin
      state_nxt.ss_hit = in_bottom;
    end
  end

  // State register; reset is synchronous like every other input
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      // Power-on: the part comes up as delivered, reserved bits at zero
      state_r <= '0;
      state_r.nv <= cmd_cfg_pkg::NV_RESET_VALUE;
      // Working copy starts as a copy of the delivered boot copy
      state_r.vol <= cmd_cfg_pkg::NV_RESET_VALUE;
      state_r.est <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Register answer and erase control, straight from the state register
  assign rsp_out              = state_r.rsp;
  assign erase_ctl_out        = state_r.ectl;
  assign erase_busy_out       = state_r.busy;

  // Datapath results, one cycle behind their inputs
  assign buf_addr_out         = state_r.baddr;
  assign small_sector_hit_out = state_r.ss_hit;

  // Reset pulse and the working copy
  assign soft_reset_out       = state_r.sreset;
  assign cfg_volatile_out     = state_r.vol;

endmodule : command_behavior_config_reg

// ==== sim/cmd_host_model.sv ====
`timescale 1ns/10ps
module cmd_host_model (
  input  wire logic                clk_in,
  output cmd_cfg_pkg::cmd_req_type cmd_out
);
  // Channel starts idle
  initial cmd_out = '0;
  // One command per call; idle fields carry inverted junk so stale values never match
  task automatic send(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d);
    @(posedge clk_in) cmd_out <= '{1'b1, op, a, d};
    @(posedge clk_in) cmd_out <= '{1'b0, ~op, ~a, ~d};
  endtask : send
endmodule : cmd_host_model

// ==== sim/command_behavior_config_reg_asserts.sv ====
`timescale 1ns/10ps
module command_behavior_config_reg_asserts (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic hw_reset_in,
  input wire cmd_cfg_pkg::cmd_req_type cmd_in,
  input wire cmd_cfg_pkg::erase_req_type erase_in,
  input wire logic [8:0] buf_addr_in,
  input wire logic top_param_in,
  input wire logic [31:0] array_addr_in,
  input wire cmd_cfg_pkg::cmd_rsp_type rsp_out,
  input wire cmd_cfg_pkg::erase_ctl_type erase_ctl_out,
  input wire logic erase_busy_out,
  input wire logic [8:0] buf_addr_out,
  input wire logic small_sector_hit_out,
  input wire logic soft_reset_out,
  input wire logic [7:0] cfg_volatile_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Command taken with no hardware reset in its cycle
  sequence s_op(logic [7:0] op);
    cmd_in.valid && cmd_in.opcode == op && !hw_reset_in;
  endsequence
  // Erase request accepted while idle
  sequence s_erase;
    erase_in.start && !erase_busy_out && !hw_reset_in;
  endsequence
  rd_data_a: assert property (s_op(8'h65) ##0 cmd_in.addr == cmd_cfg_pkg::V_REG_ADDR |=> rsp_out.valid
    && rsp_out.rdata == ($past(cfg_volatile_out) & 8'h39)) else $error("volatile read data wrong");
  buf_wrap_a: assert property (!$past(rst_in) |-> buf_addr_out ==
    ($past(buf_addr_in) & ($past(cfg_volatile_out[4]) ? 9'h1FF : 9'h0FF))) else $error("buffer wrap wrong");
  sector_hit_a: assert property (!$past(rst_in) |-> small_sector_hit_out == (!$past(cfg_volatile_out[3]) &&
    ($past(top_param_in) ? &$past(array_addr_in[31:15]) : ~|$past(array_addr_in[31:15])))) else $error("hit wrong");
  legacy_reset_a: assert property (s_op(8'hF0) |=> soft_reset_out == $past(cfg_volatile_out[0]))
    else $error("single byte reset wrong");
  pair_reset_a: assert property (s_op(8'h66) ##1 !cmd_in.valid ##1 s_op(8'h99) |=> soft_reset_out)
    else $error("two byte reset missed");
  blank_go_a: assert property (s_erase ##0 cfg_volatile_out[5] && erase_in.last_erase_ok |=>
    erase_ctl_out == 3'b100) else $error("blank read not started");
  direct_erase_a: assert property (s_erase ##0 !(cfg_volatile_out[5] && erase_in.last_erase_ok) |=>
    erase_ctl_out == 3'b010) else $error("erase not started");
  skip_done_a: assert property (erase_ctl_out.skipped |-> !erase_busy_out && $past(erase_busy_out))
    else $error("skip without idle");
endmodule : command_behavior_config_reg_asserts
bind command_behavior_config_reg command_behavior_config_reg_asserts chk (.*);

// ==== sim/command_behavior_config_reg_tb.sv ====
`timescale 1ns/10ps
`define check_eq(n, e, a) begin n_tests++; if ((a) !== (e)) begin error_cnt++; $display("Error %s exp %0h got %0h", n, e, a); end end
module command_behavior_config_reg_tb;
  localparam logic [23:0] nv_a = cmd_cfg_pkg::NV_REG_ADDR;
  localparam logic [23:0] v_a  = cmd_cfg_pkg::V_REG_ADDR;
  logic ref_clk_in, rst_in, hw_reset_in, top_param_in, erase_busy_out, small_sector_hit_out, soft_reset_out;
  logic [8:0] buf_addr_in, buf_addr_out;
  logic [31:0] array_addr_in;
  logic [7:0] cfg_volatile_out;
  cmd_cfg_pkg::cmd_req_type cmd_in;
  cmd_cfg_pkg::erase_req_type erase_in;
  cmd_cfg_pkg::blank_rsp_type blank_in;
  cmd_cfg_pkg::cmd_rsp_type rsp_out;
  cmd_cfg_pkg::erase_ctl_type erase_ctl_out;
  int error_cnt = 0;
  int n_tests = 0;
  command_behavior_config_reg uut (.*);
  cmd_host_model host (.clk_in(ref_clk_in), .cmd_out(cmd_in));
  // Free running 20 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  task automatic rd(input logic [23:0] a, input logic [7:0] e);
    host.send(8'h65, a, 8'h00);
    #1 `check_eq("rdata", e, rsp_out.rdata)
    `check_eq("rd_valid", 1'b1, rsp_out.valid)
  endtask : rd
  task automatic op(input logic [7:0] o, input logic e);
    host.send(o, 24'h000000, 8'h00);
    #1 `check_eq("soft_reset", e, soft_reset_out)
  endtask : op
  task automatic ers(input cmd_cfg_pkg::erase_kind_type k, input logic ok, input logic [2:0] e);
    @(posedge ref_clk_in) erase_in <= '{1'b1, k, ok};
    @(posedge ref_clk_in) erase_in.start <= 1'b0;
    #1 `check_eq("erase_ctl", e, erase_ctl_out)
  endtask : ers
  task automatic blk(input logic [1:0] v, input logic [2:0] e);
    @(posedge ref_clk_in) blank_in <= v;
    @(posedge ref_clk_in) blank_in <= 2'b00;
    #1 `check_eq("erase_ctl", e, erase_ctl_out)
  endtask : blk
  // Two extra edges first so a just-written volatile copy has settled
  task automatic dp(input logic [31:0] a, input logic t, input logic [8:0] eb, input logic eh);
    repeat (2) @(posedge ref_clk_in);
    buf_addr_in <= 9'h1AB;
    array_addr_in <= a;
    top_param_in <= t;
    @(posedge ref_clk_in) #1 `check_eq("buf_addr", eb, buf_addr_out)
    `check_eq("sector_hit", eh, small_sector_hit_out)
  endtask : dp
  task automatic t_defaults;
    rd(v_a, 8'h00);
    rd(nv_a, 8'h00);
    rd(24'h000100, 8'h00);
    `check_eq("err", 1'b1, rsp_out.err)
    host.send(8'h71, 24'h000100, 8'h00);
    #1 `check_eq("wr_err", 1'b1, rsp_out.err)
  endtask : t_defaults
  // Mid-run power-on reset: a fresh part with a blank boot copy
  task automatic t_power_cycle;
    @(posedge ref_clk_in) rst_in <= 1'b1;
    repeat (12) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(nv_a, 8'h00);
    rd(v_a, 8'h00);
  endtask : t_power_cycle
  task automatic t_erase;
    ers(cmd_cfg_pkg::ERASE_SECTOR, 1'b1, 3'b010);
    blk(2'b10, 3'b000);
    host.send(8'h71, v_a, 8'h20);
    ers(cmd_cfg_pkg::ERASE_BULK, 1'b0, 3'b010);
    blk(2'b10, 3'b000);
    for (int k = 0; k < 3; k++) begin
      ers(cmd_cfg_pkg::erase_kind_type'(k), 1'b1, 3'b100);
      blk(2'b10, 3'b001);
    end
    ers(cmd_cfg_pkg::ERASE_PARAM, 1'b1, 3'b100);
    blk(2'b01, 3'b010);
    blk(2'b10, 3'b000);
    `check_eq("busy", 1'b0, erase_busy_out)
  endtask : t_erase
  task automatic t_datapath;
    dp(32'h00001000, 1'b0, 9'h0AB, 1'b1);
    dp(32'h00008000, 1'b0, 9'h0AB, 1'b0);
    dp(32'hFFFF8000, 1'b1, 9'h0AB, 1'b1);
    // Layout bit written equal to the boot copy, as the host must
    host.send(8'h71, v_a, 8'hF7);
    rd(v_a, 8'h31);
    dp(32'h00001000, 1'b0, 9'h1AB, 1'b1);
  endtask : t_datapath
  task automatic t_soft_reset;
    op(8'hF0, 1'b1);
    rd(v_a, 8'h00);
    op(8'hF0, 1'b0);
    op(8'h66, 1'b0);
    op(8'h99, 1'b1);
  endtask : t_soft_reset
  // Non-volatile copy only ever gains bits; reload needs a reset
  // Runs before any erase so the layout bit is chosen up front
  task automatic t_one_time;
    host.send(8'h71, nv_a, 8'hFF);
    rd(nv_a, 8'h39);
    host.send(8'h71, nv_a, 8'h00);
    rd(nv_a, 8'h39);
    rd(v_a, 8'h00);
    @(posedge ref_clk_in) hw_reset_in <= 1'b1;
    @(posedge ref_clk_in) hw_reset_in <= 1'b0;
    #1 `check_eq("volatile", 8'h39, cfg_volatile_out)
    rd(v_a, 8'h39);
    dp(32'h00001000, 1'b0, 9'h1AB, 1'b0);
  endtask : t_one_time
  task automatic wrap_up;
    $display("Checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  // Main sequence after a 12 cycle reset
  initial begin
    rst_in = 1'b1;
    hw_reset_in = 1'b0;
    top_param_in = 1'b0;
    buf_addr_in = 9'h000;
    array_addr_in = 32'h00000000;
    erase_in = '0;
    blank_in = '0;
    repeat (12) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_defaults();
    t_one_time();
    t_power_cycle();
    t_erase();
    t_datapath();
    t_soft_reset();
    wrap_up();
  end
  // Hang guard, far beyond the hundred or so cycles the tests need
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
endmodule : command_behavior_config_reg_tb
